// ===== rtl/pts_target.sv
// pci target slave port: register window, flash window, config retry, parity
`timescale 1ns/100ps
`include "pts_cfg.svh"
module pts_target #(
    parameter int FLASH_WAIT = `PTS_FLASH_WAIT
) (
    input wire logic clock,
    input wire logic srst,
    // pci pins, sampled through two flops
    input wire logic [31:0] ad_i,
    input wire logic [3:0] cbe_n_i,
    input wire logic par_i,
    input wire logic frame_n_i,
    input wire logic irdy_n_i,
    input wire logic idsel_i,
    output pts_pkg::pts_pins_out_s pins,
    // eeprom autoload finished
    input wire logic eeprom_done,
    // user side access port
    output pts_pkg::pts_access_s access,
    input wire logic [31:0] user_rdata,
    input wire logic flash_ready,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [31:0] ad_m_q, ad_q;
    logic [3:0] cbe_m_q, cbe_q;
    logic [3:0] ctl_m_q, ctl_q;
    logic eed_m_q, eed_q, fr_m_q, fr_q;
    logic frame_n, irdy_n, par_s, idsel;

    // two flops on every pci pin and on eeprom_done and flash_ready
    always_ff @(posedge clock) begin
        ad_m_q <= ad_i;
        ad_q <= ad_m_q;
        cbe_m_q <= cbe_n_i;
        cbe_q <= cbe_m_q;
        ctl_m_q <= {par_i, frame_n_i, irdy_n_i, idsel_i};
        ctl_q <= ctl_m_q;
        eed_m_q <= eeprom_done;
        eed_q <= eed_m_q;
        fr_m_q <= flash_ready;
        fr_q <= fr_m_q;
    end
    assign {par_s, frame_n, irdy_n, idsel} = ctl_q;

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    logic [31:0] ctrl_q;
    logic [31:0] mem_bar_q, io_bar_q, flash_bar_q;
    logic [15:0] cmd_q;
    logic dpe_q, sse_q;
    logic dpe_set, sse_set, dpe_clr, sse_clr;
    logic apb_wr;

    assign apb_wr = psel && penable && pwrite;

    // bars for each window, masked to their size
    always_ff @(posedge clock) begin
        if (srst) begin
            mem_bar_q <= 32'h0000_0000;
            io_bar_q <= 32'h0000_0000;
            flash_bar_q <= 32'h0000_0000;
            cmd_q <= `PTS_CMD_RESET;
            ctrl_q <= `PTS_CTRL_RESET;
        end else if (apb_wr) begin
            case (paddr)
                `PTS_REG_CTRL: ctrl_q <= pwdata;
                `PTS_REG_MEM_BAR: mem_bar_q <= pwdata & ~32'h0000_0fff;
                `PTS_REG_IO_BAR: io_bar_q <= pwdata & ~32'h0000_003f;
                `PTS_REG_FLASH_BAR: flash_bar_q <= pwdata & ~32'h0001_ffff;
                `PTS_REG_CMD: cmd_q <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // write one to clear status; a set in the same cycle wins
    assign dpe_clr = apb_wr && paddr == `PTS_REG_STATUS && pwdata[`PTS_STS_DPE_BIT];
    assign sse_clr = apb_wr && paddr == `PTS_REG_STATUS && pwdata[`PTS_STS_SSE_BIT];
    always_ff @(posedge clock) begin
        if (srst) begin
            dpe_q <= 1'b0;
            sse_q <= 1'b0;
        end else begin
            if (dpe_set) begin
                dpe_q <= 1'b1;
            end else if (dpe_clr) begin
                dpe_q <= 1'b0;
            end
            if (sse_set) begin
                sse_q <= 1'b1;
            end else if (sse_clr) begin
                sse_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // apb read path, zero wait
    // ----------------------------------------
    logic map_ok;
    always_comb begin
        map_ok = 1'b1;
        prdata = 32'h0000_0000;
        case (paddr)
            `PTS_REG_CTRL: prdata = ctrl_q;
            `PTS_REG_STATUS: begin
                prdata[`PTS_STS_DPE_BIT] = dpe_q;
                prdata[`PTS_STS_SSE_BIT] = sse_q;
                prdata[0] = eed_q;
            end
            `PTS_REG_MEM_BAR: prdata = mem_bar_q;
            `PTS_REG_IO_BAR: prdata = io_bar_q | 32'h0000_0001;
            `PTS_REG_FLASH_BAR: prdata = flash_bar_q;
            `PTS_REG_CMD: prdata = {16'h0000, cmd_q};
            default: map_ok = 1'b0;
        endcase
    end
    assign pready = 1'b1;
    assign pslverr = psel && penable && !map_ok;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    // window hit test used by both memory windows and io
    function automatic logic win_hit(input logic [31:0] a, input logic [31:0] bar,
                                     input int bits);
        logic [31:0] m;
        m = 32'hffff_ffff << bits;
        return (a & m) == (bar & m) && bar != 32'h0000_0000;
    endfunction

    pts_pkg::pts_space_e space_dec;
    logic fr_prev_q, addr_chk_q, data_chk_q, perr_pend_q, serr_q;
    logic is_mem_cmd, is_io_cmd, is_cfg_cmd, addr_ph;
    assign addr_ph = !frame_n && fr_prev_q;
    assign is_mem_cmd = cbe_q == `PTS_CMD_MEM_RD || cbe_q == `PTS_CMD_MEM_WR ||
                        cbe_q == `PTS_CMD_MRM || cbe_q == `PTS_CMD_MRL;
    assign is_io_cmd = cbe_q == `PTS_CMD_IO_RD || cbe_q == `PTS_CMD_IO_WR;
    assign is_cfg_cmd = cbe_q == `PTS_CMD_CFG_RD || cbe_q == `PTS_CMD_CFG_WR;

    // two independent memory regions plus io and config
    always_comb begin
        space_dec = pts_pkg::PTS_SP_NONE;
        if (is_cfg_cmd && idsel) begin
            space_dec = pts_pkg::PTS_SP_CFG;
        end else if (is_mem_cmd && cmd_q[1] &&
                     win_hit(ad_q, mem_bar_q, `PTS_MEM_WIN_BITS)) begin
            space_dec = pts_pkg::PTS_SP_REG;
        end else if (is_io_cmd && cmd_q[0] &&
                     win_hit(ad_q, io_bar_q, `PTS_IO_WIN_BITS)) begin
            space_dec = pts_pkg::PTS_SP_REG;
        end else if (is_mem_cmd && cmd_q[1] &&
                     win_hit(ad_q, flash_bar_q, `PTS_FLASH_WIN_BITS)) begin
            space_dec = pts_pkg::PTS_SP_FLASH;
        end
    end

    // ----------------------------------------
    // address parity, every address phase
    // ----------------------------------------
    logic par_calc;
    pts_parity u_par (
        .ad(ad_q),
        .cbe_n(cbe_q),
        .par(par_calc)
    );

    always_ff @(posedge clock) begin
        if (srst) begin
            fr_prev_q <= 1'b1;
            addr_chk_q <= 1'b0;
        end else begin
            fr_prev_q <= frame_n;
            addr_chk_q <= addr_ph;
        end
    end

    // parity arrives one clock after the lines it covers
    logic par_bad;
    logic par_calc_q;
    always_ff @(posedge clock) begin
        if (srst) begin
            par_calc_q <= 1'b0;
        end else begin
            par_calc_q <= par_calc;
        end
    end
    assign par_bad = par_s != par_calc_q;

    // address errors set flags; serr pulse only with both enables
    logic addr_err, data_err;
    assign addr_err = addr_chk_q && par_bad;
    assign sse_set = addr_err && cmd_q[`PTS_CMD_SERR_BIT] && cmd_q[`PTS_CMD_PER_BIT];
    assign data_err = data_chk_q && par_bad;
    assign dpe_set = addr_err || data_err;

    always_ff @(posedge clock) begin
        if (srst) begin
            serr_q <= 1'b0;
        end else begin
            serr_q <= sse_set;
        end
    end

    // ----------------------------------------
    // target state machine
    // ----------------------------------------
    pts_pkg::pts_state_e st_q;
    pts_pkg::pts_space_e sp_q;
    logic wr_q;
    logic [7:0] wait_q;
    logic [31:0] rdata_q;
    logic [31:0] addr_q;
    logic oe_q, trdy_q, stop_q, devsel_q, ad_oe_q;

    always_ff @(posedge clock) begin
        if (srst) begin
            st_q <= pts_pkg::PTS_IDLE;
            sp_q <= pts_pkg::PTS_SP_NONE;
            wr_q <= 1'b0;
            wait_q <= 8'h00;
            addr_q <= 32'h0000_0000;
            oe_q <= 1'b0;
            trdy_q <= 1'b0;
            stop_q <= 1'b0;
            devsel_q <= 1'b0;
            ad_oe_q <= 1'b0;
        end else begin
            case (st_q)
                pts_pkg::PTS_IDLE: begin
                    // claim regardless of address parity result
                    if (addr_ph && space_dec != pts_pkg::PTS_SP_NONE) begin
                        sp_q <= space_dec;
                        wr_q <= cbe_q[0];
                        addr_q <= ad_q;
                        oe_q <= 1'b1;
                        devsel_q <= 1'b1;
                        ad_oe_q <= !cbe_q[0];
                        wait_q <= 8'(FLASH_WAIT);
                        if (space_dec == pts_pkg::PTS_SP_CFG && !eed_q) begin
                            st_q <= pts_pkg::PTS_RETRY;
                            stop_q <= 1'b1;
                        end else if (space_dec == pts_pkg::PTS_SP_FLASH) begin
                            st_q <= pts_pkg::PTS_WAIT;
                        end else begin
                            st_q <= pts_pkg::PTS_DATA;
                            trdy_q <= 1'b1;
                            stop_q <= 1'b1;
                        end
                    end
                end
                pts_pkg::PTS_WAIT: begin
                    // trdy held off until flash ready and wait elapsed
                    if (wait_q != 8'h00) begin
                        wait_q <= wait_q - 8'h01;
                    end else if (fr_q) begin
                        st_q <= pts_pkg::PTS_DATA;
                        trdy_q <= 1'b1;
                        stop_q <= 1'b1;
                    end
                end
                pts_pkg::PTS_DATA: begin
                    // irdy waits tolerated; one transfer then disconnect
                    if (!irdy_n) begin
                        trdy_q <= 1'b0;
                        st_q <= pts_pkg::PTS_BUSY;
                    end
                end
                pts_pkg::PTS_BUSY: begin
                    // stop stays until frame released, then turn around
                    if (frame_n) begin
                        stop_q <= 1'b0;
                        devsel_q <= 1'b0;
                        ad_oe_q <= 1'b0;
                        st_q <= pts_pkg::PTS_TURN;
                    end
                end
                pts_pkg::PTS_RETRY: begin
                    // retry: stop without trdy, no record kept
                    if (frame_n) begin
                        stop_q <= 1'b0;
                        devsel_q <= 1'b0;
                        ad_oe_q <= 1'b0;
                        st_q <= pts_pkg::PTS_TURN;
                    end
                end
                pts_pkg::PTS_TURN: begin
                    // one clock of driven high before release
                    oe_q <= 1'b0;
                    sp_q <= pts_pkg::PTS_SP_NONE;
                    st_q <= pts_pkg::PTS_IDLE;
                end
                default: st_q <= pts_pkg::PTS_IDLE;
            endcase
        end
    end

    // read data captured into a flop before it drives ad
    always_ff @(posedge clock) begin
        if (srst) begin
            rdata_q <= 32'h0000_0000;
        end else if (st_q != pts_pkg::PTS_DATA) begin
            rdata_q <= user_rdata;
        end
    end

    // data parity checked on write phases; no termination follows
    always_ff @(posedge clock) begin
        if (srst) begin
            data_chk_q <= 1'b0;
            perr_pend_q <= 1'b0;
        end else begin
            data_chk_q <= st_q == pts_pkg::PTS_DATA && wr_q && !irdy_n;
            perr_pend_q <= data_err && cmd_q[`PTS_CMD_PER_BIT];
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    logic par_out_q, par_oe_q;
    always_ff @(posedge clock) begin
        if (srst) begin
            par_out_q <= 1'b0;
            par_oe_q <= 1'b0;
        end else begin
            par_out_q <= ^{rdata_q, cbe_q};
            par_oe_q <= ad_oe_q;
        end
    end

    assign pins.ad_o = rdata_q;
    assign pins.ad_oe = ad_oe_q;
    assign pins.par_o = par_out_q;
    assign pins.par_oe = par_oe_q;
    assign pins.devsel_n_o = !devsel_q;
    assign pins.trdy_n_o = !trdy_q;
    assign pins.stop_n_o = !stop_q;
    assign pins.ctl_oe = oe_q;
    assign pins.perr_n_o = !perr_pend_q;
    assign pins.perr_oe = perr_pend_q;
    assign pins.serr_n_o = 1'b0; // open drain low
    assign pins.serr_oe = serr_q;

    // user access request, memory registers hold contents outside
    assign access.req = st_q == pts_pkg::PTS_DATA && !irdy_n;
    assign access.wr = wr_q;
    assign access.space = sp_q;
    assign access.addr = addr_q[16:0];
    assign access.wdata = ad_q;
    assign access.be_n = cbe_q;
endmodule

// ===== rtl/pts_cfg.svh
// constants for the pci target slave port
`ifndef PTS_CFG_SVH
`define PTS_CFG_SVH
// apb register offsets (byte addresses)
`define PTS_REG_CTRL 12'h000
`define PTS_REG_STATUS 12'h004
`define PTS_REG_MEM_BAR 12'h008
`define PTS_REG_IO_BAR 12'h00c
`define PTS_REG_FLASH_BAR 12'h010
`define PTS_REG_CMD 12'h014
// command register field positions
`define PTS_CMD_PER_BIT 6
`define PTS_CMD_SERR_BIT 8
// status register field positions
`define PTS_STS_SSE_BIT 14
`define PTS_STS_DPE_BIT 15
// window sizes as address bit counts
`define PTS_MEM_WIN_BITS 12
`define PTS_IO_WIN_BITS 6
`define PTS_FLASH_WIN_BITS 17
// reset values
`define PTS_CTRL_RESET 32'h0000_0000
`define PTS_CMD_RESET 16'h0000
// flash access time in ns and derived wait clocks at 25 mhz
`define PTS_FLASH_NS 200
`define PTS_CLK_NS 40
`define PTS_FLASH_WAIT ((`PTS_FLASH_NS + `PTS_CLK_NS - 1) / `PTS_CLK_NS)
// pci bus commands
`define PTS_CMD_IO_RD 4'h2
`define PTS_CMD_IO_WR 4'h3
`define PTS_CMD_MEM_RD 4'h6
`define PTS_CMD_MEM_WR 4'h7
`define PTS_CMD_CFG_RD 4'ha
`define PTS_CMD_CFG_WR 4'hb
`define PTS_CMD_MRM 4'hc
`define PTS_CMD_MRL 4'he
`endif

// ===== rtl/pts_pkg.sv
// types for the pci target slave port
package pts_pkg;
    typedef enum logic [5:0] {
        PTS_IDLE = 6'b000001,
        PTS_WAIT = 6'b000010,
        PTS_DATA = 6'b000100,
        PTS_RETRY = 6'b001000,
        PTS_TURN = 6'b010000,
        PTS_BUSY = 6'b100000
    } pts_state_e;

    typedef enum logic [2:0] {
        PTS_SP_NONE = 3'h0,
        PTS_SP_REG = 3'h1,
        PTS_SP_FLASH = 3'h2,
        PTS_SP_CFG = 3'h3
    } pts_space_e;

    // pins driven by the target, each with its enable
    typedef struct packed {
        logic [31:0] ad_o;
        logic ad_oe;
        logic par_o;
        logic par_oe;
        logic devsel_n_o;
        logic trdy_n_o;
        logic stop_n_o;
        logic ctl_oe;
        logic perr_n_o;
        logic perr_oe;
        logic serr_n_o;
        logic serr_oe;
    } pts_pins_out_s;

    // user-side access towards the register window, flash and config space
    typedef struct packed {
        logic req;
        logic wr;
        pts_space_e space;
        logic [16:0] addr;
        logic [31:0] wdata;
        logic [3:0] be_n;
    } pts_access_s;
endpackage

// ===== rtl/pts_parity.sv
// even parity over address/data and command lines
`timescale 1ns/100ps
module pts_parity (
    input wire logic [31:0] ad,
    input wire logic [3:0] cbe_n,
    output logic par
);
    // pci parity makes the 37-bit group even
    assign par = ^{ad, cbe_n};
endmodule

// ===== tb/pts_target_sva.sv
// assertion checker for the pci target slave port
`timescale 1ns/100ps
`include "pts_cfg.svh"
module pts_target_sva #(
    parameter int FLASH_WAIT = `PTS_FLASH_WAIT
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic irdy_n_i,
    input wire logic eeprom_done,
    input wire pts_pkg::pts_pins_out_s pins,
    input wire pts_pkg::pts_access_s access,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata
);
    logic [15:0] cmd_q;
    int wait_q;
    // mirror of the command register, taken from apb writes
    always_ff @(posedge clock) begin
        if (srst) begin
            cmd_q <= `PTS_CMD_RESET;
        end else if (psel && penable && pwrite && paddr == `PTS_REG_CMD) begin
            cmd_q <= pwdata[15:0];
        end
    end
    // clocks spent claimed while trdy is still held off
    always_ff @(posedge clock) begin
        if (srst || !pins.ctl_oe || pins.devsel_n_o || !pins.trdy_n_o) begin
            wait_q <= 0;
        end else begin
            wait_q <= wait_q + 1;
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);
    sequence s_disc;
        pins.ctl_oe && !pins.trdy_n_o && !pins.stop_n_o;
    endsequence
    sequence s_free;
        ##[0:6] (pins.devsel_n_o || !pins.ctl_oe);
    endsequence
    property p_stop_with_trdy;
        pins.ctl_oe && $fell(pins.trdy_n_o) |-> s_disc;
    endproperty
    a_stop_with_trdy: assert property (p_stop_with_trdy) else $error("trdy without stop");
    property p_one_phase;
        pins.ctl_oe && $rose(pins.trdy_n_o) |-> pins.trdy_n_o throughout s_free;
    endproperty
    a_one_phase: assert property (p_one_phase) else $error("second data phase");
    property p_flash_wait;
        $fell(pins.trdy_n_o) && wait_q != 0 |-> wait_q >= FLASH_WAIT;
    endproperty
    a_flash_wait: assert property (p_flash_wait) else $error("flash wait short");
    property p_req_single;
        access.req |=> !access.req [*4];
    endproperty
    a_req_single: assert property (p_req_single) else $error("repeated access");
    property p_release;
        pins.ctl_oe && !pins.stop_n_o && !irdy_n_i |-> ##[1:5] (pins.stop_n_o || !pins.ctl_oe);
    endproperty
    a_release: assert property (p_release) else $error("stop not released");
    property p_retry;
        !eeprom_done && pins.ctl_oe |-> pins.trdy_n_o;
    endproperty
    a_retry: assert property (p_retry) else $error("transfer before load");
    property p_perr_en;
        pins.perr_oe && !pins.perr_n_o |-> cmd_q[`PTS_CMD_PER_BIT];
    endproperty
    a_perr_en: assert property (p_perr_en) else $error("perr while disabled");
    property p_serr_pulse;
        $rose(pins.serr_oe) |=> !pins.serr_oe;
    endproperty
    a_serr_pulse: assert property (p_serr_pulse) else $error("serr too long");
    property p_serr_en;
        $rose(pins.serr_oe) |-> cmd_q[`PTS_CMD_SERR_BIT] && cmd_q[`PTS_CMD_PER_BIT];
    endproperty
    a_serr_en: assert property (p_serr_en) else $error("serr while disabled");
endmodule

bind pts_target pts_target_sva #(.FLASH_WAIT(FLASH_WAIT)) i_sva (
    .clock(clock), .srst(srst), .irdy_n_i(irdy_n_i), .eeprom_done(eeprom_done),
    .pins(pins), .access(access), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata)
);

// ===== tb/pts_host_model.sv
// pci initiator model standing in for the host bridge
`timescale 1ns/100ps
module pts_host_model (
    input wire logic clock,
    input wire pts_pkg::pts_pins_out_s pins,
    output logic [31:0] ad,
    output logic [3:0] cbe_n,
    output logic par,
    output logic frame_n,
    output logic irdy_n,
    output logic idsel
);
    logic flip;
    logic got_trdy;
    logic got_stop;
    logic [31:0] rdata;
    // idle bus: control lines pulled up
    initial begin
        ad = 32'h0;
        cbe_n = 4'hf;
        par = 1'b0;
        frame_n = 1'b1;
        irdy_n = 1'b1;
        idsel = 1'b0;
        flip = 1'b0;
    end
    // parity lags its phase by one clock; flip corrupts it on request
    always @(posedge clock) begin
        par <= ^{ad, cbe_n} ^ flip;
    end
    // one transaction with a single data phase, optional irdy wait states
    task automatic xfer(input logic [3:0] cmd, input logic [31:0] addr, input logic [3:0] be_n,
            input logic [31:0] wdata, input int waits, input logic sel, input logic [1:0] bad);
        int n;
        @(posedge clock);
        frame_n <= 1'b0;
        ad <= addr;
        cbe_n <= cmd;
        idsel <= sel;
        flip <= bad[0];
        @(posedge clock);
        ad <= cmd[0] ? wdata : ~addr;
        cbe_n <= be_n;
        idsel <= 1'b0;
        flip <= bad[1];
        repeat (waits) @(posedge clock);
        frame_n <= 1'b1;
        irdy_n <= 1'b0;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (!(pins.ctl_oe && !(pins.trdy_n_o && pins.stop_n_o)) && n < 40);
        got_trdy = pins.ctl_oe && !pins.trdy_n_o;
        got_stop = pins.ctl_oe && !pins.stop_n_o;
        rdata = pins.ad_o;
        irdy_n <= 1'b1;
        ad <= ~ad;
        cbe_n <= ~cbe_n;
        flip <= 1'b0;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pins.ctl_oe && n < 10);
    endtask
endmodule

// ===== tb/pci_target_slave_port_bench.sv
// self-checking bench for the pci target slave port
`timescale 1ns/100ps
`include "pts_cfg.svh"
module pci_target_slave_port_bench;
    typedef struct packed {
        logic [3:0] cmd;
        logic [31:0] addr;
        logic sel;
        logic [31:0] data;
        pts_pkg::pts_space_e space;
    } pts_row_s;
    localparam pts_pkg::pts_space_e RG = pts_pkg::PTS_SP_REG;
    localparam pts_row_s ROWS [8] = '{
        '{`PTS_CMD_MEM_RD, 32'h1000_0010, 1'b0, 32'ha5a5_0001, RG},
        '{`PTS_CMD_MEM_WR, 32'h1000_0ffc, 1'b0, 32'h0bad_cafe, RG},
        '{`PTS_CMD_IO_RD, 32'h0000_0400, 1'b0, 32'h1111_2222, RG},
        '{`PTS_CMD_IO_WR, 32'h0000_043c, 1'b0, 32'h3333_4444, RG},
        '{`PTS_CMD_MEM_RD, 32'h2001_fffc, 1'b0, 32'h0000_00ef, pts_pkg::PTS_SP_FLASH},
        '{`PTS_CMD_MEM_WR, 32'h2000_0000, 1'b0, 32'h0000_005a, pts_pkg::PTS_SP_FLASH},
        '{`PTS_CMD_CFG_RD, 32'h0000_0000, 1'b1, 32'h1234_5678, pts_pkg::PTS_SP_CFG},
        '{`PTS_CMD_CFG_WR, 32'h0000_0004, 1'b1, 32'h0000_0147, pts_pkg::PTS_SP_CFG}
    };
    // parity cases: command value, address, corrupted phase, flags, status
    localparam logic [31:0] PC [4] = '{32'h0043, 32'h0003, 32'h0143, 32'h0103};
    localparam logic [31:0] PA [4] = '{32'h1000_0020, 32'h1000_0020, 32'h3000_0000, 32'h1000_0024};
    localparam logic [1:0] PB [4] = '{2'b10, 2'b10, 2'b01, 2'b01};
    localparam logic [1:0] PE [4] = '{2'b10, 2'b00, 2'b01, 2'b00};
    localparam logic [1:0] PK [4] = '{2'b11, 2'b11, 2'b00, 2'b11};
    localparam logic [31:0] PS [4] = '{32'h8001, 32'h8001, 32'hc001, 32'h8001};
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic eeprom_done = 1'b0;
    logic flash_ready = 1'b1;
    logic [31:0] user_rdata = 32'h0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic err;
    logic [31:0] rd;
    logic [31:0] h_ad;
    logic [3:0] h_cbe_n;
    logic h_par, h_frame_n, h_irdy_n, h_idsel;
    pts_pkg::pts_pins_out_s pins;
    pts_pkg::pts_access_s access;
    pts_pkg::pts_access_s acc_q;
    int bad_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int perr_cnt = 0;
    int serr_cnt = 0;
    int req_cnt = 0;

    always #20 clock = ~clock;

    // the shared lines carry whoever drives them
    pts_target #(.FLASH_WAIT(1)) i_dut (
        .clock(clock), .srst(srst), .ad_i(pins.ad_oe ? pins.ad_o : h_ad), .cbe_n_i(h_cbe_n),
        .par_i(pins.par_oe ? pins.par_o : h_par), .frame_n_i(h_frame_n), .irdy_n_i(h_irdy_n),
        .idsel_i(h_idsel), .pins(pins), .eeprom_done(eeprom_done), .access(access),
        .user_rdata(user_rdata), .flash_ready(flash_ready), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr)
    );
    pts_host_model i_host (
        .clock(clock), .pins(pins), .ad(h_ad), .cbe_n(h_cbe_n), .par(h_par),
        .frame_n(h_frame_n), .irdy_n(h_irdy_n), .idsel(h_idsel)
    );

    // counts error pulses and accesses, cuts a hang short
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if ((pins.perr_oe && !pins.perr_n_o) === 1'b1) perr_cnt <= perr_cnt + 1;
        if ((pins.serr_oe && !pins.serr_n_o) === 1'b1) serr_cnt <= serr_cnt + 1;
        if (access.req === 1'b1) begin
            acc_q <= access;
            req_cnt <= req_cnt + 1;
        end
        if (cyc == 20000) begin
            bad_count++;
            test_done();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic test_done;
        if (bad_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        int i;
        int n;
        int m;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        repeat (3) @(posedge clock);
        chk({31'h0, pins.ctl_oe}, 32'h0);
        apb(1'b0, `PTS_REG_CTRL, 32'h0);
        chk(rd, `PTS_CTRL_RESET);
        apb(1'b0, 12'h100, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, `PTS_REG_MEM_BAR, 32'h1000_0000);
        apb(1'b1, `PTS_REG_IO_BAR, 32'h0000_0400);
        apb(1'b1, `PTS_REG_FLASH_BAR, 32'h2000_0000);
        apb(1'b1, `PTS_REG_CMD, 32'h0000_0003);
        n = req_cnt;
        i_host.xfer(`PTS_CMD_CFG_RD, 32'h0000_0008, 4'h0, 32'h0, 0, 1'b1, 2'b00);
        chk({30'h0, i_host.got_trdy, i_host.got_stop}, 32'h1);
        chk(32'(req_cnt - n), 32'h0);
        eeprom_done <= 1'b1;
        repeat (4) @(posedge clock);
        for (i = 0; i < 8; i++) begin
            n = req_cnt;
            user_rdata <= ROWS[i].data;
            i_host.xfer(ROWS[i].cmd, ROWS[i].addr, ROWS[i].space == RG ? 4'h0 : 4'he,
                        ROWS[i].data, i % 3, ROWS[i].sel, 2'b00);
            chk({30'h0, i_host.got_trdy, i_host.got_stop}, 32'h3);
            chk(32'(req_cnt - n), 32'h1);
            chk({28'h0, acc_q.space, acc_q.wr}, {28'h0, ROWS[i].space, ROWS[i].cmd[0]});
            chk({15'h0, acc_q.addr}, {15'h0, ROWS[i].addr[16:0]});
            chk(ROWS[i].cmd[0] ? acc_q.wdata : i_host.rdata, ROWS[i].data);
        end
        flash_ready <= 1'b0;
        user_rdata <= 32'h0000_c3c3;
        n = cyc;
        fork
            i_host.xfer(`PTS_CMD_MEM_RD, 32'h2000_0100, 4'hc, 32'h0, 3, 1'b0, 2'b00);
            begin
                repeat (12) @(posedge clock);
                flash_ready <= 1'b1;
            end
        join
        chk({31'h0, cyc - n > 14}, 32'h1);
        chk(i_host.rdata, 32'h0000_c3c3);
        chk({30'h0, i_host.got_trdy, i_host.got_stop}, 32'h3);
        for (i = 0; i < 4; i++) begin
            apb(1'b1, `PTS_REG_CMD, PC[i]);
            n = perr_cnt;
            m = serr_cnt;
            i_host.xfer(`PTS_CMD_MEM_WR, PA[i], 4'h0, 32'h600d_0000, 0, 1'b0, PB[i]);
            chk({30'h0, perr_cnt != n, serr_cnt == m + 1}, {30'h0, PE[i]});
            chk({30'h0, i_host.got_trdy, i_host.got_stop}, {30'h0, PK[i]});
            apb(1'b0, `PTS_REG_STATUS, 32'h0);
            chk(rd, PS[i]);
            apb(1'b1, `PTS_REG_STATUS, 32'h0000_c000);
        end
        test_done();
    end
endmodule
